/* vlt_device.sv */
/*
 Switch-side VLAN table and learned address table with indirect
 host access, plus the per-packet lookup and learning decisions.
 Assumes packet headers arrive one per cycle already parsed, and
 that the static table result is supplied from outside.
*/
// Function
// R01 - VLAN table used only when mode set
// R02 - Sixteen 22-bit entries, valid/members/group/id
// R03 - Membership bit n means port n+1
// R04 - Entries reset valid, all ports, group 0, id 1
// R05 - Lookups keyed on filter group plus address
// R06 - Untagged or null id takes port default
// R07 - Invalid entry drops packet, no learning
// R08 - Unknown destination floods members except ingress
// R09 - Unknown source is learned
// R10 - Select register picks table and direction
// R11 - Trigger write starts operation with index
// R12 - VLAN read fills last three data registers
// R13 - Host loads data before select and trigger
// R14 - Host writes VLAN entries from entry zero
// R15 - Learned table 1K entries, host read-only
// R16 - Bit 68 flags an empty learned table
// R17 - Bits 67-58 give valid count minus one
// R18 - Two-bit aging stamp per learned entry
// R19 - Bit 55 set means reread from 114
// R20 - Bits 54-52 encode learning port
// R21 - Learned read spans data registers 112-120
// R22 - Host may start learned read at 114
// R23 - Only the host master changes the VLAN table
// R24 - Read data settles quickly, held until trigger
`timescale 1ns/10ps
module vlt_device import vlt_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_b,
    vlt_if.dev mgmt,
    input wire logic vlan_mode,
    input wire logic [59:0] port_dflt_vid,
    input wire logic age_tick,
    input wire logic pkt_valid,
    input wire logic [2:0] pkt_port,
    input wire logic pkt_tagged,
    input wire logic [11:0] pkt_vid,
    input wire logic [47:0] pkt_da,
    input wire logic [47:0] pkt_sa,
    input wire logic static_hit,
    input wire logic [4:0] static_ports,
    output logic fwd_valid,
    output logic fwd_drop,
    output logic [4:0] fwd_ports,
    output logic [11:0] fwd_vid,
    output logic [3:0] fwd_fgrp
);
    logic [7:0] sel_reg, trig_reg;
    logic [7:0] dat_reg [VLT_DAT_N];
    logic [21:0] vlan_tab_reg [VLT_VLAN_N];
    logic [56:0] lrn_tab_reg [VLT_LRN_N];
    logic [VLT_LRN_N-1:0] lrn_vld_reg;
    logic [10:0] lrn_cnt_reg;
    logic [1:0] age_reg;
    logic pend_reg, trig_wr, lrn_trig, dat_wr, in_dat, hit_v, s1_vld, s1_drop, s1_shit;
    logic da_hit, sa_hit, learn_en;
    logic [3:0] dat_idx, s1_fgrp;
    logic [9:0] lrn_idx_reg, rd_idx, cnt_m1, da_idx, sa_idx;
    logic [56:0] rd_ent, da_e;
    logic [71:0] lrn_word;
    logic [11:0] in_vid, s1_vid;
    logic [21:0] hit_e;
    logic [4:0] s1_memb, s1_sports, in_mask, da_ports;
    logic [2:0] s1_port;
    logic [47:0] s1_da, s1_sa;

    // Register port decode
    assign trig_wr = mgmt.reg_wr && (mgmt.reg_addr == VLT_TRIG_OFS);
    assign lrn_trig = trig_wr && ((sel_reg & VLT_SEL_LRN_MASK) == VLT_SEL_LRN_RD); // R10
    assign in_dat = (mgmt.reg_addr >= VLT_D68_64_OFS) && (mgmt.reg_addr <= VLT_D7_0_OFS);
    assign dat_idx = 4'(mgmt.reg_addr - VLT_D68_64_OFS);
    // Top data byte is read-only, the rest of the data block is RW
    assign dat_wr = mgmt.reg_wr && in_dat && (mgmt.reg_addr != VLT_D68_64_OFS); // R15

    // Select and trigger registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_reg <= VLT_RST_BYTE;
            trig_reg <= VLT_RST_BYTE;
        end else if (mgmt.reg_wr && mgmt.reg_addr == VLT_SEL_OFS) begin
            sel_reg <= mgmt.reg_wdata; // R10
        end else if (trig_wr) begin
            trig_reg <= mgmt.reg_wdata; // R11
        end
    end

    // Learned read index: upper bits from select, low byte from trigger
    assign rd_idx = pend_reg ? lrn_idx_reg : {sel_reg[1:0], mgmt.reg_wdata}; // R11
    assign rd_ent = lrn_vld_reg[rd_idx] ? lrn_tab_reg[rd_idx] : 57'h0;
    assign cnt_m1 = (lrn_cnt_reg == 11'h000) ? 10'h000 : 10'(lrn_cnt_reg - 11'h001); // R17
    // Empty flag, count, stamp, ready bit, port, group, address
    assign lrn_word = {3'b000, lrn_cnt_reg == 11'h000, cnt_m1, rd_ent[56:55], // R16
        1'b0, rd_ent[54:0]}; // R21

    // A slot rewritten by learning in the trigger cycle is reloaded next cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_reg <= 1'b0;
            lrn_idx_reg <= 10'h000;
        end else begin
            pend_reg <= lrn_trig && learn_en && (sa_idx == rd_idx); // R19
            if (lrn_trig) begin
                lrn_idx_reg <= rd_idx;
            end
        end
    end

    // Data registers: table loads take priority over host writes
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < VLT_DAT_N; i++) begin
                dat_reg[i] <= VLT_RST_BYTE;
            end
        end else if (lrn_trig || pend_reg) begin
            for (int i = 0; i < VLT_DAT_N; i++) begin
                dat_reg[i] <= lrn_word[71-8*i -: 8]; // R21
            end
        end else if (trig_wr && sel_reg == VLT_SEL_VLAN_RD) begin
            dat_reg[6] <= {2'b00, vlan_tab_reg[mgmt.reg_wdata[3:0]][21:16]}; // R12
            dat_reg[7] <= vlan_tab_reg[mgmt.reg_wdata[3:0]][15:8];
            dat_reg[8] <= vlan_tab_reg[mgmt.reg_wdata[3:0]][7:0];
        end else if (dat_wr) begin
            dat_reg[dat_idx] <= mgmt.reg_wdata; // R24
        end
    end

    // Answer one cycle after the strobe, byte held until the next read
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mgmt.reg_rvalid <= 1'b0;
            mgmt.reg_rdata <= VLT_RST_BYTE;
        end else begin
            mgmt.reg_rvalid <= mgmt.reg_rd;
            if (mgmt.reg_rd && mgmt.reg_addr == VLT_SEL_OFS) begin
                mgmt.reg_rdata <= sel_reg;
            end else if (mgmt.reg_rd && mgmt.reg_addr == VLT_TRIG_OFS) begin
                mgmt.reg_rdata <= trig_reg;
            end else if (mgmt.reg_rd && mgmt.reg_addr == VLT_D55_48_OFS) begin
                mgmt.reg_rdata <= dat_reg[2] | (pend_reg ? VLT_PEND_MASK : 8'h00); // R19
            end else if (mgmt.reg_rd && in_dat) begin
                mgmt.reg_rdata <= dat_reg[dat_idx];
            end else if (mgmt.reg_rd) begin
                mgmt.reg_rdata <= VLT_RST_BYTE; // R24
            end
        end
    end

    // VLAN table; only the host trigger path writes it
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < VLT_VLAN_N; i++) begin
                vlan_tab_reg[i] <= VLT_VE_RST; // R04
            end
        end else if (trig_wr && sel_reg == VLT_SEL_VLAN_WR) begin
            vlan_tab_reg[mgmt.reg_wdata[3:0]] <= {dat_reg[6][5:0], dat_reg[7], dat_reg[8]}; // R02
        end
    end

    // Ingress id and VLAN match; lowest matching entry wins
    always_comb begin
        if (!pkt_tagged || pkt_vid == 12'h000) begin
            in_vid = port_dflt_vid[12*pkt_port +: 12]; // R06
        end else begin
            in_vid = pkt_vid;
        end
        hit_v = 1'b0;
        hit_e = VLT_VE_RST;
        for (int i = VLT_VLAN_N - 1; i >= 0; i--) begin
            if (vlan_tab_reg[i][11:0] == in_vid) begin
                hit_v = 1'b1;
                hit_e = vlan_tab_reg[i];
            end
        end
    end

    // First stage: VLAN result; mode off means one group, all ports
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_vld <= 1'b0;
            s1_drop <= 1'b0;
        end else begin
            s1_vld <= pkt_valid;
            s1_drop <= vlan_mode && !(hit_v && hit_e[VLT_VE_VALID]); // R07
        end
    end

    // First stage payload, no reset needed behind the valid bit
    always_ff @(posedge sys_clk) begin
        s1_fgrp <= vlan_mode ? hit_e[VLT_VE_FGRP_LO +: 4] : 4'h0; // R01
        s1_memb <= vlan_mode ? hit_e[VLT_VE_MEMB_LO +: 5] : VLT_ALL_PORTS; // R01
        s1_vid <= in_vid;
        s1_port <= pkt_port;
        s1_da <= pkt_da;
        s1_sa <= pkt_sa;
        s1_shit <= static_hit;
        s1_sports <= static_ports;
    end

    vlt_hash u_hash_da (
        .key({s1_fgrp, s1_da}),
        .idx(da_idx)
    );
    vlt_hash u_hash_sa (
        .key({s1_fgrp, s1_sa}),
        .idx(sa_idx)
    );

    // Second stage compares; group is part of the key
    assign da_e = lrn_tab_reg[da_idx];
    assign da_hit = lrn_vld_reg[da_idx] && (da_e[51:0] == {s1_fgrp, s1_da}); // R05
    assign sa_hit = lrn_vld_reg[sa_idx] && (lrn_tab_reg[sa_idx][51:0] == {s1_fgrp, s1_sa}); // R05
    assign learn_en = s1_vld && !s1_drop; // R07
    assign in_mask = 5'(5'h01 << s1_port); // R03
    assign da_ports = 5'(5'h01 << da_e[54:52]); // R20

    // Forwarding decision; static result outranks learned
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fwd_valid <= 1'b0;
            fwd_drop <= 1'b0;
            fwd_ports <= 5'h00;
            fwd_vid <= 12'h000;
            fwd_fgrp <= 4'h0;
        end else begin
            fwd_valid <= s1_vld;
            fwd_drop <= s1_drop;
            fwd_vid <= s1_vid;
            fwd_fgrp <= s1_fgrp;
            if (s1_drop) begin
                fwd_ports <= 5'h00; // R07
            end else if (s1_shit) begin
                fwd_ports <= s1_sports & ~in_mask;
            end else if (da_hit) begin
                fwd_ports <= da_ports & ~in_mask;
            end else begin
                fwd_ports <= s1_memb & ~in_mask; // R08
            end
        end
    end

    // Learned entries: new sources learned, known ones restamped
    always_ff @(posedge sys_clk) begin
        if (learn_en) begin
            lrn_tab_reg[sa_idx] <= {age_reg, s1_port, s1_fgrp, s1_sa}; // R09
        end
    end

    // Slot occupancy, valid count and aging epoch
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lrn_vld_reg <= '0;
            lrn_cnt_reg <= 11'h000;
            age_reg <= 2'b00;
        end else begin
            if (age_tick) begin
                age_reg <= age_reg + 2'b01; // R18
            end
            if (learn_en && !sa_hit) begin
                lrn_vld_reg[sa_idx] <= 1'b1; // R09
                if (!lrn_vld_reg[sa_idx]) begin
                    lrn_cnt_reg <= lrn_cnt_reg + 11'h001; // R17
                end
            end
        end
    end
endmodule // vlt_device

/* vlt_hash.sv */
/*
 Folds a filter group plus address key into a learned table slot.
 Purely combinational; the caller registers around it.
*/
`timescale 1ns/10ps
module vlt_hash import vlt_pkg::*; (
    input wire logic [51:0] key,
    output logic [VLT_LRN_AW-1:0] idx
);
    // Xor folding keeps slot spread even for sequential addresses
    assign idx = key[9:0] ^ key[19:10] ^ key[29:20] ^ key[39:30]
        ^ key[49:40] ^ {8'h00, key[51:50]};
endmodule // vlt_hash

/* vlt_host.sv */
/*
 Management master end: turns one table command into the sequence
 of indirect register writes and reads, retrying the ready byte.
 Assumes the device answers each read strobe one cycle later.
*/
`timescale 1ns/10ps
module vlt_host import vlt_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_b,
    vlt_if.host mgmt,
    input wire logic cmd_valid,
    input wire vlt_op_t cmd_op,
    input wire logic [9:0] cmd_index,
    input wire logic [21:0] cmd_wdata,
    output logic cmd_ready,
    output logic res_valid,
    output logic [68:0] res_data
);
    typedef enum logic [1:0] {
        VLT_ST_IDLE = 2'b00,
        VLT_ST_WRITE = 2'b01,
        VLT_ST_READ = 2'b11,
        VLT_ST_WAIT = 2'b10
    } vlt_st_t;

    vlt_st_t st_reg;
    vlt_op_t op_reg;
    logic [9:0] idx_reg;
    logic [21:0] wd_reg;
    logic [2:0] step_reg;
    logic [7:0] rd_addr_reg;
    logic [71:0] buf_reg;
    logic [7:0] sel_code;

    // Select code for the command held
    always_comb begin
        case (op_reg)
            VLT_OP_VLAN_WR: sel_code = VLT_SEL_VLAN_WR;
            VLT_OP_VLAN_RD: sel_code = VLT_SEL_VLAN_RD;
            default: sel_code = VLT_SEL_LRN_RD | {6'h00, idx_reg[9:8]};
        endcase
    end

    // Sequencer; data bytes go before select and trigger
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= VLT_ST_IDLE;
            op_reg <= VLT_OP_VLAN_RD;
            idx_reg <= 10'h000;
            wd_reg <= 22'h000000;
            step_reg <= 3'h0;
            rd_addr_reg <= VLT_D68_64_OFS;
            buf_reg <= '0;
            cmd_ready <= 1'b1;
            res_valid <= 1'b0;
            res_data <= '0;
            mgmt.reg_wr <= 1'b0;
            mgmt.reg_rd <= 1'b0;
            mgmt.reg_addr <= VLT_RST_BYTE;
            mgmt.reg_wdata <= VLT_RST_BYTE;
        end else begin
            res_valid <= 1'b0;
            mgmt.reg_wr <= 1'b0;
            mgmt.reg_rd <= 1'b0;
            case (st_reg)
                VLT_ST_IDLE: begin
                    if (cmd_valid) begin
                        op_reg <= cmd_op;
                        idx_reg <= cmd_index;
                        wd_reg <= cmd_wdata;
                        buf_reg <= '0;
                        // Only writes need the three data bytes first
                        step_reg <= (cmd_op == VLT_OP_VLAN_WR) ? 3'h0 : 3'h3; // R13
                        rd_addr_reg <= (cmd_op == VLT_OP_VLAN_RD) ? VLT_D23_16_OFS
                            : VLT_D68_64_OFS;
                        cmd_ready <= 1'b0;
                        st_reg <= VLT_ST_WRITE;
                    end
                end
                VLT_ST_WRITE: begin
                    mgmt.reg_wr <= 1'b1;
                    step_reg <= step_reg + 3'h1;
                    case (step_reg)
                        3'h0: begin
                            mgmt.reg_addr <= VLT_D23_16_OFS;
                            mgmt.reg_wdata <= {2'b00, wd_reg[21:16]}; // R13
                        end
                        3'h1: begin
                            mgmt.reg_addr <= VLT_D15_8_OFS;
                            mgmt.reg_wdata <= wd_reg[15:8];
                        end
                        3'h2: begin
                            mgmt.reg_addr <= VLT_D7_0_OFS;
                            mgmt.reg_wdata <= wd_reg[7:0];
                        end
                        3'h3: begin
                            mgmt.reg_addr <= VLT_SEL_OFS;
                            mgmt.reg_wdata <= sel_code; // R10
                        end
                        default: begin
                            mgmt.reg_addr <= VLT_TRIG_OFS;
                            mgmt.reg_wdata <= idx_reg[7:0]; // R11
                            if (op_reg == VLT_OP_VLAN_WR) begin
                                cmd_ready <= 1'b1;
                                res_valid <= 1'b1;
                                st_reg <= VLT_ST_IDLE;
                            end else begin
                                st_reg <= VLT_ST_READ;
                            end
                        end
                    endcase
                end
                VLT_ST_READ: begin
                    mgmt.reg_rd <= 1'b1;
                    mgmt.reg_addr <= rd_addr_reg;
                    st_reg <= VLT_ST_WAIT;
                end
                default: begin
                    if (mgmt.reg_rvalid) begin
                        if (rd_addr_reg == VLT_D55_48_OFS && mgmt.reg_rdata[7]) begin
                            st_reg <= VLT_ST_READ; // R19 R22
                        end else begin
                            buf_reg <= {buf_reg[63:0], mgmt.reg_rdata};
                            if (rd_addr_reg == VLT_D7_0_OFS) begin
                                res_data <= {buf_reg[60:0], mgmt.reg_rdata};
                                res_valid <= 1'b1;
                                cmd_ready <= 1'b1;
                                st_reg <= VLT_ST_IDLE;
                            end else begin
                                rd_addr_reg <= rd_addr_reg + 8'h01;
                                st_reg <= VLT_ST_READ;
                            end
                        end
                    end
                end
            endcase
        end
    end
endmodule // vlt_host

/* vlt_if.sv */
/*
 Indirect register port between the management master and the
 switch table block. Single-cycle write and read strobes.
 Assumes both ends share sys_clk.
*/
`timescale 1ns/10ps
interface vlt_if;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    modport dev(input reg_wr, input reg_rd, input reg_addr, input reg_wdata,
        output reg_rdata, output reg_rvalid);
    modport host(output reg_wr, output reg_rd, output reg_addr, output reg_wdata,
        input reg_rdata, input reg_rvalid);
endinterface

/* vlt_pkg.sv */
/*
 Constants and types shared by both ends of the VLAN and learned
 address table access path: register offsets, select codes, entry
 field positions, reset values and table sizes.
 Assumes an 8-bit indirect register port between the two ends.
*/
package vlt_pkg;
    // Indirect access registers
    localparam logic [7:0] VLT_SEL_OFS = 8'h6e;
    localparam logic [7:0] VLT_TRIG_OFS = 8'h6f;
    localparam logic [7:0] VLT_D68_64_OFS = 8'h70;
    localparam logic [7:0] VLT_D63_56_OFS = 8'h71;
    localparam logic [7:0] VLT_D55_48_OFS = 8'h72;
    localparam logic [7:0] VLT_D47_40_OFS = 8'h73;
    localparam logic [7:0] VLT_D39_32_OFS = 8'h74;
    localparam logic [7:0] VLT_D31_24_OFS = 8'h75;
    localparam logic [7:0] VLT_D23_16_OFS = 8'h76;
    localparam logic [7:0] VLT_D15_8_OFS = 8'h77;
    localparam logic [7:0] VLT_D7_0_OFS = 8'h78;
    localparam int VLT_DAT_N = 9;
    localparam logic [7:0] VLT_RST_BYTE = 8'h00;
    // Select codes
    localparam logic [7:0] VLT_SEL_VLAN_RD = 8'h14;
    localparam logic [7:0] VLT_SEL_VLAN_WR = 8'h04;
    localparam logic [7:0] VLT_SEL_LRN_RD = 8'h18;
    localparam logic [7:0] VLT_SEL_LRN_MASK = 8'hfc;
    localparam logic [7:0] VLT_PEND_MASK = 8'h80;
    // Table sizes
    localparam int VLT_NPORT = 5;
    localparam int VLT_VLAN_N = 16;
    localparam int VLT_LRN_N = 1024;
    localparam int VLT_LRN_AW = 10;
    // VLAN entry layout and reset value
    localparam int VLT_VE_VALID = 21;
    localparam int VLT_VE_MEMB_LO = 16;
    localparam int VLT_VE_FGRP_LO = 12;
    localparam logic [21:0] VLT_VE_RST = 22'h3f0001;
    localparam logic [4:0] VLT_ALL_PORTS = 5'h1f;
    // Learned entry layout as read back
    localparam int VLT_LE_EMPTY = 68;
    localparam int VLT_LE_CNT_LO = 58;
    localparam int VLT_LE_STAMP_LO = 56;
    localparam int VLT_LE_PEND = 55;
    localparam int VLT_LE_PORT_LO = 52;
    localparam int VLT_LE_FGRP_LO = 48;
    // Cycles from trigger edge to stable data registers, worst case
    localparam int VLT_RD_CYC = 2;
    typedef enum logic [1:0] {
        VLT_OP_VLAN_RD = 2'h0,
        VLT_OP_VLAN_WR = 2'h1,
        VLT_OP_LRN_RD = 2'h2
    } vlt_op_t;
endpackage

/* vlt_props.sv */
/*
 Checker for the indirect register port joining host and device ends.
 Assumes one sys_clk and the interface signals as plain inputs.
*/
`timescale 1ns/10ps
module vlt_props import vlt_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    logic [7:0] sel_reg;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // Last select code, so a read can be judged by its table
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_reg <= 8'h00;
        end else if (reg_wr && reg_addr == VLT_SEL_OFS) begin
            sel_reg <= reg_wdata;
        end
    end
    a_rd_answered: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    a_answer_has_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("answer without a read");
    a_strobes_apart: assert property (!(reg_wr && reg_rd))
        else $error("write and read strobes together");
    a_rdata_held: assert property (!reg_rvalid |-> $stable(reg_rdata))
        else $error("read byte moved between reads");
    a_top_byte_narrow: assert property (reg_rd && reg_addr == VLT_D68_64_OFS
        |=> reg_rdata[7:5] == 3'h0)
        else $error("top learned byte wider than five bits");
    a_vlan_hi_narrow: assert property (reg_rd && reg_addr == VLT_D23_16_OFS
        && sel_reg == VLT_SEL_VLAN_RD |=> reg_rdata[7:6] == 2'h0)
        else $error("vlan high byte wider than six bits");
    a_reads_spaced: assert property (reg_rd |=> !reg_rd)
        else $error("reads issued back to back");
    a_trig_after_sel: assert property (reg_wr && reg_addr == VLT_TRIG_OFS
        |-> $past(reg_wr) && $past(reg_addr) == VLT_SEL_OFS)
        else $error("trigger not preceded by select");
    a_vlan_wr_order: assert property (reg_wr && reg_addr == VLT_SEL_OFS
        && reg_wdata == VLT_SEL_VLAN_WR |-> $past(reg_addr, 1) == VLT_D7_0_OFS
        && $past(reg_addr, 3) == VLT_D23_16_OFS)
        else $error("vlan write select before data bytes");
    // Main scenarios seen on the port
    c_vlan_write: cover property (reg_wr && reg_addr == VLT_TRIG_OFS
        && sel_reg == VLT_SEL_VLAN_WR);
    c_lrn_read: cover property (reg_rd && reg_addr == VLT_D68_64_OFS
        && sel_reg == VLT_SEL_LRN_RD);
    c_vlan_read: cover property (reg_rvalid && sel_reg == VLT_SEL_VLAN_RD);
endmodule // vlt_props

/* vlt_tb.sv */
/*
 Self-checking bench: host end and device end joined by the port.
 Assumes inputs change 1 ns after each rising sys_clk edge.
*/
`timescale 1ns/10ps
module vlt_tb import vlt_pkg::*;;
    logic sys_clk = 0, rst_b = 0, vlan_mode = 0, pkt_valid = 0, pkt_tagged = 0, age_tick = 0;
    logic cmd_valid = 0, cmd_ready, res_valid, fwd_valid, fwd_drop;
    logic [59:0] port_dflt_vid = 60'h00a000000000;
    logic [2:0] pkt_port = 3'h0;
    logic [11:0] pkt_vid = 12'h000, fwd_vid;
    logic [47:0] pkt_da = 48'h0, pkt_sa = 48'h0;
    vlt_op_t cmd_op = VLT_OP_VLAN_RD;
    logic [9:0] cmd_index = 10'h000;
    logic [21:0] cmd_wdata = 22'h0;
    logic [68:0] res_data, res;
    logic [4:0] fwd_ports;
    logic [3:0] fwd_fgrp;
    int bad_count = 0, checks_done = 0;
    vlt_if vlt_if_i();
    vlt_device vlt_device_i(.sys_clk(sys_clk), .rst_b(rst_b), .mgmt(vlt_if_i),
        .vlan_mode(vlan_mode), .port_dflt_vid(port_dflt_vid), .age_tick(age_tick),
        .pkt_valid(pkt_valid), .pkt_port(pkt_port), .pkt_tagged(pkt_tagged),
        .pkt_vid(pkt_vid), .pkt_da(pkt_da), .pkt_sa(pkt_sa), .static_hit(1'b0),
        .static_ports(5'h00), .fwd_valid(fwd_valid), .fwd_drop(fwd_drop),
        .fwd_ports(fwd_ports), .fwd_vid(fwd_vid), .fwd_fgrp(fwd_fgrp));
    vlt_host vlt_host_i(.sys_clk(sys_clk), .rst_b(rst_b), .mgmt(vlt_if_i),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_index(cmd_index),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .res_valid(res_valid),
        .res_data(res_data));
    vlt_props vlt_props_i(.sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(vlt_if_i.reg_wr),
        .reg_rd(vlt_if_i.reg_rd), .reg_addr(vlt_if_i.reg_addr),
        .reg_wdata(vlt_if_i.reg_wdata), .reg_rdata(vlt_if_i.reg_rdata),
        .reg_rvalid(vlt_if_i.reg_rvalid));
    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;
    // Verdict in one place
    task results;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task check(input logic [68:0] got, input logic [68:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One host command, bounded waits on ready and completion
    task run_cmd(input vlt_op_t op, input logic [9:0] idx, input logic [21:0] wd);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (n >= 50) begin
            bad_count++;
            results;
        end
        cmd_op = op;
        cmd_index = idx;
        cmd_wdata = wd;
        cmd_valid = 1'b1;
        @(posedge sys_clk);
        #1 cmd_valid = 1'b0;
        n = 0;
        while (res_valid !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (n >= 100) begin
            bad_count++;
            results;
        end
        res = res_data;
    endtask
    // One packet; returns in the cycle its forwarding result stands
    task pkt(input logic [2:0] p, input logic t, input logic [11:0] v,
        input logic [47:0] da, input logic [47:0] sa);
        int n;
        {pkt_port, pkt_tagged, pkt_vid, pkt_da, pkt_sa} = {p, t, v, da, sa};
        pkt_valid = 1'b1;
        @(posedge sys_clk);
        #1 pkt_valid = 1'b0;
        n = 0;
        while (fwd_valid !== 1'b1 && n < 4) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (n >= 4) begin
            bad_count++;
            results;
        end
    endtask
    task test_reset_vals;
        run_cmd(VLT_OP_VLAN_RD, 10'h000, 22'h0);
        check(res, {47'h0, VLT_VE_RST});
        run_cmd(VLT_OP_VLAN_RD, 10'h00f, 22'h0);
        check(res, {47'h0, VLT_VE_RST});
        run_cmd(VLT_OP_LRN_RD, 10'h000, 22'h0);
        check(res[68:58], {1'b1, 10'h000});
        $display("test reset_vals done");
    endtask
    // Entries written from zero upward, then read back
    task test_vlan_rw;
        logic [21:0] ents [3];
        ents = '{22'h39300a, 22'h1f000b, 22'h2250c0};
        for (int i = 0; i < 3; i++) begin
            run_cmd(VLT_OP_VLAN_WR, 10'(i), ents[i]);
        end
        for (int i = 2; i >= 0; i--) begin
            run_cmd(VLT_OP_VLAN_RD, 10'(i), 22'h0);
            check(res, {47'h0, ents[i]});
        end
        $display("test vlan_rw done");
    endtask
    task test_lookup;
        vlan_mode = 1'b1;
        pkt(3'h0, 1'b1, 12'h00a, 48'hd1, 48'h5a1);
        check({fwd_drop, fwd_ports, fwd_vid, fwd_fgrp}, {6'h18, 12'h00a, 4'h3});
        pkt(3'h3, 1'b1, 12'h000, 48'hd2, 48'h5a2);
        check({fwd_drop, fwd_ports, fwd_vid, fwd_fgrp}, {6'h11, 12'h00a, 4'h3});
        pkt(3'h3, 1'b0, 12'h0c0, 48'hd2, 48'h5a2);
        check({fwd_drop, fwd_ports, fwd_vid}, {6'h11, 12'h00a});
        pkt(3'h1, 1'b1, 12'h00b, 48'hd3, 48'h5a3);
        check({fwd_drop, fwd_ports}, 6'h20);
        // New aging epoch, so the next restamp shows in the entry
        age_tick = 1'b1;
        @(posedge sys_clk);
        #1 age_tick = 1'b0;
        pkt(3'h3, 1'b1, 12'h00a, 48'h5a1, 48'h5a2);
        check({fwd_drop, fwd_ports}, 6'h01);
        run_cmd(VLT_OP_LRN_RD, 10'h000, 22'h0);
        check(res[68:58], {1'b0, 10'h001});
        check(res[55], 1'b0);
        // Slot of group 3 plus source 0x5a2 under the xor fold; upper index via select
        run_cmd(VLT_OP_LRN_RD, 10'h2a3, 22'h0);
        check(res, {1'b0, 10'h001, 2'b01, 1'b0, 3'h3, 4'h3, 48'h5a2});
        vlan_mode = 1'b0;
        pkt(3'h1, 1'b1, 12'h00b, 48'hd4, 48'h5a4);
        check({fwd_drop, fwd_fgrp}, 5'h00);
        $display("test lookup done");
    endtask
    // Reset for 16 cycles, then the scenarios
    initial begin
        repeat (16) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        test_reset_vals();
        test_vlan_rw();
        test_lookup();
        results();
    end
endmodule // vlt_tb
